/* File: gms_cfg.svh */
`ifndef GMS_CFG_SVH
`define GMS_CFG_SVH

// ****************************************************************
// Timing
// ****************************************************************
`define GMS_CLK_PERIOD_NS     10
`define GMS_SAMPLE_PERIOD_NS  1000000
`define GMS_MICROSECOND_NS    1000
`define GMS_SETTLE_TIME_NS    1000000
`define GMS_STARTUP_TIME_NS   100000000

// ****************************************************************
// Register offsets (byte addresses)
// ****************************************************************
`define GMS_REG_CTRL          4'h0
`define GMS_REG_CONFIG        4'h4
`define GMS_REG_STATUS        4'h8
`define GMS_REG_LATENCY       4'hc

// ****************************************************************
// Control register bits (write one to act)
// ****************************************************************
`define GMS_CTRL_RESET        0
`define GMS_CTRL_REQ_PART     1
`define GMS_CTRL_REQ_SERIAL   2
`define GMS_CTRL_REQ_CONFIG   3
`define GMS_CTRL_SVC_ENTER    4
`define GMS_CTRL_SVC_NORMAL   5
`define GMS_CTRL_SVC_INIT     6

// ****************************************************************
// Configuration register fields and reset values
// ****************************************************************
`define GMS_CFG_TRIG_BIT      0
`define GMS_CFG_DIV_LSB       8
`define GMS_CFG_DIV_MSB       15
`define GMS_CFG_TRIG_RESET    1'b0
`define GMS_CFG_DIV_RESET     8'h04

// ****************************************************************
// Status byte bit positions
// ****************************************************************
`define GMS_ST_INTEGRITY      7
`define GMS_ST_STARTUP        6
`define GMS_ST_OPCOND         5
`define GMS_ST_OVERLOAD       4
`define GMS_ST_CHANNEL        3

`endif

/* File: gms_pkg.sv */
package gms_pkg;

	// Operating modes of the sequencer
	typedef enum logic [2:0]
	{
		MODE_INIT_SETTLE,
		MODE_INIT_PART,
		MODE_INIT_SERIAL,
		MODE_INIT_CONFIG,
		MODE_INIT_FLUSH,
		MODE_NORMAL,
		MODE_SERVICE
	} gms_mode_e;

	// Datagram kinds handed to the transmitter
	typedef enum logic [1:0]
	{
		KIND_PART,
		KIND_SERIAL,
		KIND_CONFIG,
		KIND_MEASURE
	} gms_kind_e;

endpackage : gms_pkg

/* File: gms_sequencer.sv */
// The placing of the registers and the Avalon-MM interface to the registers are this design's own decisions.
`timescale 1ns/1ps
`include "gms_cfg.svh"

module gms_sequencer #(
	parameter int AXES           = 3,
	parameter int SAMPLE_CYCLES  = `GMS_SAMPLE_PERIOD_NS / `GMS_CLK_PERIOD_NS,
	parameter int SETTLE_CYCLES  = `GMS_SETTLE_TIME_NS / `GMS_CLK_PERIOD_NS,
	parameter int STARTUP_CYCLES = `GMS_STARTUP_TIME_NS / `GMS_CLK_PERIOD_NS
)(
	// Clock and reset
	input  wire logic                CLOCK,
	input  wire logic                RESETN,
	// Device pins
	input  wire logic                EXTERNAL_RESET_LOW,
	input  wire logic                TRIGGER_INPUT,
	// Measurement front end
	input  wire logic [AXES*24-1:0]  RATE_SAMPLE,
	input  wire logic                ERR_INTEGRITY,
	input  wire logic                ERR_OPCOND,
	input  wire logic                ERR_OVERLOAD,
	input  wire logic                ERR_CHANNEL,
	input  wire logic [2:0]          ERR_AXIS,
	output logic                     CHANNEL_SYNC,
	output logic                     SAMPLE_STROBE,
	// Datagram transmitter
	output logic                     TX_VALID,
	input  wire logic                TX_READY,
	output logic [1:0]               TX_KIND,
	output logic [7:0]               TX_STATUS,
	output logic [AXES*8-1:0]        TX_RATE_BYTE_HIGH,
	output logic [AXES*8-1:0]        TX_RATE_BYTE_MID,
	output logic [AXES*8-1:0]        TX_RATE_BYTE_LOW,
	output logic [15:0]              TX_LATENCY,
	// Avalon-MM slave
	input  wire logic [3:0]          AVS_ADDRESS,
	input  wire logic                AVS_READ,
	input  wire logic                AVS_WRITE,
	input  wire logic [31:0]         AVS_WRITEDATA,
	input  wire logic [3:0]          AVS_BYTEENABLE,
	output logic [31:0]              AVS_READDATA,
	output logic                     AVS_WAITREQUEST
);

	localparam int US_CYCLES = `GMS_MICROSECOND_NS / `GMS_CLK_PERIOD_NS;

	// ****************************************************************
	// Elaboration checks
	// ****************************************************************
	if (AXES < 1 || AXES > 3)
	begin : g_bad_axes
		$error("AXES must be 1 to 3");
	end
	if (SAMPLE_CYCLES < 2 || SETTLE_CYCLES < 1 || STARTUP_CYCLES < 1 || US_CYCLES > 4096)
	begin : g_bad_counts
		$error("Timing counts out of range");
	end

	// ****************************************************************
	// Declarations
	// ****************************************************************
	logic                 rst_s1_reg;
	logic                 rst_n;
	logic                 ers_s1_reg, ers_s2_reg, ers_s3_reg, ext_level_reg;
	logic                 trg_s1_reg, trg_s2_reg, trg_s3_reg, trg_level_reg;
	logic                 trig_fall;
	gms_pkg::gms_mode_e   mode_reg, mode_next;
	gms_pkg::gms_kind_e   launch_kind, tx_kind_reg;
	logic                 launch;
	logic                 can_launch;
	logic [31:0]          cnt_reg, cnt_next;
	logic [31:0]          st_cnt_reg;
	logic                 startup_reg, startup_next;
	logic [31:0]          smp_cnt_reg;
	logic                 tick;
	logic [7:0]           dec_cnt_reg;
	logic [7:0]           div_eff;
	logic                 dec_hit;
	logic [11:0]          us_pre_reg;
	logic [15:0]          lat_us_reg, trig_lat_reg;
	logic [2:0]           req_reg, req_next, req_set, req_clr;
	logic                 meas_pend_reg, meas_set;
	logic                 cfg_trig_reg;
	logic [7:0]           cfg_div_reg;
	logic                 ack_reg;
	logic                 bus_acc;
	logic                 wr_ctrl, wr_cfg;
	logic [31:0]          rd_mux;
	logic [7:0]           status_w;
	logic [23:0]          sample_reg [AXES];
	logic                 in_normal;

	// ****************************************************************
	// Reset release and pin synchronisers
	// ****************************************************************
	// Release the block reset through two flip-flops
	always_ff @(posedge CLOCK or negedge RESETN)
	begin
		if (!RESETN)
		begin
			rst_s1_reg <= 1'b0;
			rst_n      <= 1'b0;
		end
		else
		begin
			rst_s1_reg <= 1'b1;
			rst_n      <= rst_s1_reg;
		end
	end

	// Pin levels count once the second and third stages agree; idle high as pulled up
	always_ff @(posedge CLOCK or negedge rst_n)
	begin
		if (!rst_n)
		begin
			{ers_s1_reg, ers_s2_reg, ers_s3_reg, ext_level_reg} <= 4'hf;
			{trg_s1_reg, trg_s2_reg, trg_s3_reg, trg_level_reg} <= 4'hf;
		end
		else
		begin
			{ers_s1_reg, ers_s2_reg, ers_s3_reg} <= {EXTERNAL_RESET_LOW, ers_s1_reg, ers_s2_reg};
			{trg_s1_reg, trg_s2_reg, trg_s3_reg} <= {TRIGGER_INPUT, trg_s1_reg, trg_s2_reg};
			if (ers_s2_reg == ers_s3_reg)
				ext_level_reg <= ers_s3_reg;
			if (trg_s2_reg == trg_s3_reg)
				trg_level_reg <= trg_s3_reg;
		end
	end

	// Falling edge only; rising edges never start a transmission
	assign trig_fall = (trg_s2_reg == trg_s3_reg) & ~trg_s3_reg & trg_level_reg;

	// ****************************************************************
	// Internal sampling and latency
	// ****************************************************************
	assign in_normal = (mode_reg == gms_pkg::MODE_NORMAL);
	assign tick      = (smp_cnt_reg == 32'(SAMPLE_CYCLES - 1));
	assign div_eff   = (cfg_div_reg == 8'h00) ? 8'h01 : cfg_div_reg;
	assign dec_hit   = tick & in_normal & (dec_cnt_reg == div_eff - 8'h01);

	// Sample clock runs except while channels are held in reset
	always_ff @(posedge CLOCK or negedge rst_n)
	begin
		if (!rst_n)
		begin
			smp_cnt_reg <= 32'h0;
			dec_cnt_reg <= 8'h00;
		end
		else
		begin
			if (mode_reg == gms_pkg::MODE_INIT_SETTLE || tick)
				smp_cnt_reg <= 32'h0;
			else
				smp_cnt_reg <= smp_cnt_reg + 32'h1;
			if (!in_normal || dec_hit)
				dec_cnt_reg <= 8'h00;
			else if (tick)
				dec_cnt_reg <= dec_cnt_reg + 8'h01;
		end
	end

	// Latest sample per axis; older ones are simply overwritten
	for (genvar a = 0; a < AXES; a++)
	begin : g_axis
		always_ff @(posedge CLOCK or negedge rst_n)
		begin
			if (!rst_n)
				sample_reg[a] <= 24'h0;
			else if (tick)
				sample_reg[a] <= RATE_SAMPLE[a*24 +: 24];
		end
		always_ff @(posedge CLOCK or negedge rst_n)
		begin
			if (!rst_n)
				{TX_RATE_BYTE_HIGH[a*8 +: 8], TX_RATE_BYTE_MID[a*8 +: 8],
					TX_RATE_BYTE_LOW[a*8 +: 8]} <= 24'h0;
			else if (launch && launch_kind == gms_pkg::KIND_MEASURE)
				{TX_RATE_BYTE_HIGH[a*8 +: 8], TX_RATE_BYTE_MID[a*8 +: 8],
					TX_RATE_BYTE_LOW[a*8 +: 8]} <= sample_reg[a];
		end
	end

	// Microseconds since the last sample; saturates rather than wrapping
	always_ff @(posedge CLOCK or negedge rst_n)
	begin
		if (!rst_n)
		begin
			us_pre_reg   <= 12'h0;
			lat_us_reg   <= 16'h0;
			trig_lat_reg <= 16'h0;
		end
		else
		begin
			us_pre_reg <= (tick || us_pre_reg == 12'(US_CYCLES - 1)) ? 12'h0 : us_pre_reg + 12'h1;
			if (tick)
				lat_us_reg <= 16'h0;
			else if (us_pre_reg == 12'(US_CYCLES - 1) && lat_us_reg != 16'hffff)
				lat_us_reg <= lat_us_reg + 16'h1;
			if (trig_fall)
				trig_lat_reg <= lat_us_reg;
		end
	end

	// ****************************************************************
	// Mode sequencer
	// ****************************************************************
	assign can_launch = ~TX_VALID;

	// Next mode and datagram launch; external reset overrides everything
	always_comb
	begin
		mode_next   = mode_reg;
		launch      = 1'b0;
		launch_kind = gms_pkg::KIND_MEASURE;
		case (mode_reg)
			gms_pkg::MODE_INIT_SETTLE:
				if (cnt_reg == 32'(SETTLE_CYCLES - 1))
					mode_next = gms_pkg::MODE_INIT_PART;
			gms_pkg::MODE_INIT_PART:
				if (can_launch)
				begin
					launch      = 1'b1;
					launch_kind = gms_pkg::KIND_PART;
					mode_next   = gms_pkg::MODE_INIT_SERIAL;
				end
			gms_pkg::MODE_INIT_SERIAL:
				if (can_launch)
				begin
					launch      = 1'b1;
					launch_kind = gms_pkg::KIND_SERIAL;
					mode_next   = gms_pkg::MODE_INIT_CONFIG;
				end
			gms_pkg::MODE_INIT_CONFIG:
				if (can_launch)
				begin
					launch      = 1'b1;
					launch_kind = gms_pkg::KIND_CONFIG;
					mode_next   = gms_pkg::MODE_INIT_FLUSH;
				end
			gms_pkg::MODE_INIT_FLUSH:
				if (can_launch)
					mode_next = gms_pkg::MODE_NORMAL;
			gms_pkg::MODE_NORMAL:
				if (wr_ctrl && AVS_WRITEDATA[`GMS_CTRL_RESET])
					mode_next = gms_pkg::MODE_INIT_SETTLE;
				else if (wr_ctrl && AVS_WRITEDATA[`GMS_CTRL_SVC_ENTER])
					mode_next = gms_pkg::MODE_SERVICE;
				else if (can_launch && req_reg != 3'b000)
				begin
					launch      = 1'b1;
					launch_kind = req_reg[0] ? gms_pkg::KIND_PART :
						(req_reg[1] ? gms_pkg::KIND_SERIAL : gms_pkg::KIND_CONFIG);
				end
				else if (can_launch && meas_pend_reg)
					launch = 1'b1;
			gms_pkg::MODE_SERVICE:
				if (wr_ctrl && AVS_WRITEDATA[`GMS_CTRL_SVC_INIT])
					mode_next = gms_pkg::MODE_INIT_SETTLE;
				else if (wr_ctrl && AVS_WRITEDATA[`GMS_CTRL_SVC_NORMAL])
					mode_next = gms_pkg::MODE_NORMAL;
			default:
				mode_next = gms_pkg::MODE_INIT_SETTLE;
		endcase
		if (!ext_level_reg)
		begin
			mode_next = gms_pkg::MODE_INIT_SETTLE;
			launch    = 1'b0;
		end
	end

	// Settle counter restarts on every entry and while the reset pin is low
	assign cnt_next = (mode_reg == gms_pkg::MODE_INIT_SETTLE && mode_next == mode_reg && ext_level_reg)
		? cnt_reg + 32'h1 : 32'h0;

	// Start-up flag only on the init-to-normal path, never from service
	assign startup_next = (mode_reg == gms_pkg::MODE_INIT_FLUSH && mode_next == gms_pkg::MODE_NORMAL)
		| (startup_reg & (mode_next == gms_pkg::MODE_NORMAL)
		& (st_cnt_reg != 32'(STARTUP_CYCLES - 1)));

	// Mode state and counters
	always_ff @(posedge CLOCK or negedge rst_n)
	begin
		if (!rst_n)
		begin
			mode_reg     <= gms_pkg::MODE_INIT_SETTLE;
			cnt_reg      <= 32'h0;
			startup_reg  <= 1'b0;
			st_cnt_reg   <= 32'h0;
			CHANNEL_SYNC <= 1'b1;
		end
		else
		begin
			mode_reg     <= mode_next;
			cnt_reg      <= cnt_next;
			startup_reg  <= startup_next;
			st_cnt_reg   <= startup_next ? st_cnt_reg + 32'h1 : 32'h0;
			CHANNEL_SYNC <= (mode_next == gms_pkg::MODE_INIT_SETTLE);
		end
	end

	// ****************************************************************
	// Pending requests and transmit hand-off
	// ****************************************************************
	assign req_set = (wr_ctrl && in_normal) ? AVS_WRITEDATA[`GMS_CTRL_REQ_CONFIG:`GMS_CTRL_REQ_PART]
		: 3'b000;
	assign req_clr = {launch && in_normal && launch_kind == gms_pkg::KIND_CONFIG,
		launch && in_normal && launch_kind == gms_pkg::KIND_SERIAL,
		launch && in_normal && launch_kind == gms_pkg::KIND_PART};
	assign req_next = (mode_next == gms_pkg::MODE_NORMAL) ? ((req_reg & ~req_clr) | req_set) : 3'b000;

	// Trigger in trigger mode, decimation otherwise; service ignores both
	assign meas_set = in_normal & (cfg_trig_reg ? trig_fall : dec_hit);

	// Status byte: errors never hold back a datagram
	assign status_w[`GMS_ST_INTEGRITY] = ERR_INTEGRITY;
	assign status_w[`GMS_ST_STARTUP]   = startup_reg;
	assign status_w[`GMS_ST_OPCOND]    = ERR_OPCOND;
	assign status_w[`GMS_ST_OVERLOAD]  = ERR_OVERLOAD;
	assign status_w[`GMS_ST_CHANNEL]   = ERR_CHANNEL;
	assign status_w[2:0]               = ERR_AXIS;

	// Datagram hand-off holds until the transmitter takes it
	always_ff @(posedge CLOCK or negedge rst_n)
	begin
		if (!rst_n)
		begin
			req_reg       <= 3'b000;
			meas_pend_reg <= 1'b0;
			TX_VALID      <= 1'b0;
			tx_kind_reg   <= gms_pkg::KIND_PART;
			TX_STATUS     <= 8'h00;
			TX_LATENCY    <= 16'h0;
			SAMPLE_STROBE <= 1'b0;
		end
		else
		begin
			req_reg       <= req_next;
			meas_pend_reg <= in_normal & (meas_set | (meas_pend_reg & ~(launch
				&& launch_kind == gms_pkg::KIND_MEASURE)));
			TX_VALID      <= launch | (TX_VALID & ~TX_READY);
			SAMPLE_STROBE <= tick;
			if (launch)
			begin
				tx_kind_reg <= launch_kind;
				TX_STATUS   <= status_w;
				TX_LATENCY  <= cfg_trig_reg ? trig_lat_reg : lat_us_reg;
			end
		end
	end

	assign TX_KIND = tx_kind_reg;

	// ****************************************************************
	// Avalon-MM slave: one wait state on every access
	// ****************************************************************
	assign bus_acc         = AVS_READ | AVS_WRITE;
	assign AVS_WAITREQUEST = bus_acc & ~ack_reg;
	assign wr_ctrl = AVS_WRITE & ack_reg & AVS_BYTEENABLE[0] & (AVS_ADDRESS == `GMS_REG_CTRL);
	assign wr_cfg  = AVS_WRITE & ack_reg & (AVS_ADDRESS == `GMS_REG_CONFIG);
	assign rd_mux  = (AVS_ADDRESS == `GMS_REG_CONFIG) ? {16'h0, cfg_div_reg, 7'h00, cfg_trig_reg} :
		(AVS_ADDRESS == `GMS_REG_STATUS) ? {16'h0, 3'b000, TX_VALID, 1'b0, 3'(mode_reg), status_w} :
		(AVS_ADDRESS == `GMS_REG_LATENCY) ? {16'h0, trig_lat_reg} : 32'h0;

	// Bus state and the configuration register
	always_ff @(posedge CLOCK or negedge rst_n)
	begin
		if (!rst_n)
		begin
			ack_reg      <= 1'b0;
			AVS_READDATA <= 32'h0;
			cfg_trig_reg <= `GMS_CFG_TRIG_RESET;
			cfg_div_reg  <= `GMS_CFG_DIV_RESET;
		end
		else
		begin
			ack_reg <= bus_acc & ~ack_reg;
			if (AVS_READ && !ack_reg)
				AVS_READDATA <= rd_mux;
			if (wr_cfg && AVS_BYTEENABLE[0])
				cfg_trig_reg <= AVS_WRITEDATA[`GMS_CFG_TRIG_BIT];
			if (wr_cfg && AVS_BYTEENABLE[1])
				cfg_div_reg <= AVS_WRITEDATA[`GMS_CFG_DIV_MSB:`GMS_CFG_DIV_LSB];
		end
	end

	// ****************************************************************
	// Assertions
	// ****************************************************************
	default clocking cb @(posedge CLOCK); endclocking
	default disable iff (!rst_n);

	sequence s_part_sent;
		mode_reg == gms_pkg::MODE_INIT_PART && launch;
	endsequence
	sequence s_serial_then_config;
		mode_reg == gms_pkg::MODE_INIT_SERIAL ##1
			(mode_reg == gms_pkg::MODE_INIT_SERIAL || mode_reg == gms_pkg::MODE_INIT_SETTLE
			|| TX_KIND == 2'(gms_pkg::KIND_SERIAL));
	endsequence

	AST_INIT_ORDER: assert property (s_part_sent |=> s_serial_then_config)
		else $error("Serial datagram did not follow part number");
	AST_EXT_RESET: assert property (!ext_level_reg |=> mode_reg == gms_pkg::MODE_INIT_SETTLE
		&& cnt_reg == 32'h0)
		else $error("Reset pin low did not hold initialization");
	AST_INIT_NO_TRIG: assert property ((mode_reg == gms_pkg::MODE_INIT_PART && !TX_VALID
		&& ext_level_reg) |=> TX_VALID && TX_KIND == 2'(gms_pkg::KIND_PART))
		else $error("Part number datagram waited on something");
	AST_STARTUP_SET: assert property ((mode_reg == gms_pkg::MODE_INIT_FLUSH
		&& mode_next == gms_pkg::MODE_NORMAL) |=> startup_reg && in_normal)
		else $error("Start-up flag not raised entering normal");
	AST_NO_STARTUP: assert property ((mode_reg == gms_pkg::MODE_SERVICE
		&& mode_next == gms_pkg::MODE_NORMAL) |=> !startup_reg)
		else $error("Start-up flag raised after service exit");
	AST_SERVICE_QUIET: assert property (mode_reg == gms_pkg::MODE_SERVICE |-> !launch
		##1 !meas_pend_reg)
		else $error("Datagram launched in service mode");
	AST_TRIG_ONLY: assert property ((in_normal && cfg_trig_reg && !trig_fall && !meas_pend_reg)
		|=> !meas_pend_reg)
		else $error("Measurement queued without trigger edge");
	AST_STATUS_BIT6: assert property (launch |=> TX_STATUS[6] == $past(startup_reg))
		else $error("Status start-up bit wrong");
	AST_RATE_BYTES: assert property ((launch && launch_kind == gms_pkg::KIND_MEASURE)
		|=> {TX_RATE_BYTE_HIGH[7:0], TX_RATE_BYTE_MID[7:0], TX_RATE_BYTE_LOW[7:0]}
		== $past(sample_reg[0]))
		else $error("Rate bytes not split high middle low");

endmodule : gms_sequencer

/* File: gms_host_model.sv */
`timescale 1ns/1ps

// ****************************************************************
// Host-side datagram sink
// ****************************************************************
// A real host may lag, so when slow it accepts only every fourth cycle
module gms_host_model #(
	parameter int AXES = 3
)(
	// Clock and reset
	input  wire logic               clock,
	input  wire logic               resetn,
	// Datagram link
	input  wire logic               tx_valid,
	output logic                    tx_ready,
	input  wire logic [1:0]         tx_kind,
	input  wire logic [7:0]         tx_status,
	input  wire logic [AXES*24-1:0] tx_rate,
	// Control and capture
	input  wire logic               slow,
	output logic [15:0]             seen,
	output logic [1:0]              kind,
	output logic [7:0]              status,
	output logic [AXES*24-1:0]      rate
);
	logic [1:0] wait_reg;

	// Capture every accepted datagram; status kept for the host to examine
	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
			{tx_ready, seen, kind, status, rate, wait_reg} <= '0;
		else
		begin
			wait_reg <= wait_reg + 2'h1;
			if (tx_valid && tx_ready)
			begin
				seen     <= seen + 16'h1;
				kind     <= tx_kind;
				status   <= tx_status;
				rate     <= tx_rate;
				tx_ready <= 1'b0;
			end
			else
				tx_ready <= tx_valid && (!slow || wait_reg == 2'h3);
		end
	end
endmodule : gms_host_model

/* File: tb.sv */
`timescale 1ns/1ps
`include "gms_cfg.svh"

// ****************************************************************
// Testbench
// ****************************************************************
module tb;
	logic        clock = 1'b0, resetn = 1'b0, ext_n = 1'b1, trig = 1'b1, slow = 1'b1;
	logic        rd = 1'b0, wr = 1'b0, wait_req, tx_valid, tx_ready, ch_sync, strobe;
	logic [3:0]  addr = 4'h0, ben = 4'hf;
	logic [31:0] wdata = 32'h0, rdata, q;
	logic [71:0] sample = 72'h7fff00_01f2e3_9a5c31, rate;
	logic [6:0]  errs = 7'h15;
	logic [1:0]  tx_kind, kind;
	logic [7:0]  tx_status, status;
	logic [23:0] hi, md, lo;
	logic [15:0] seen, lat;
	int          err_count = 0, checked = 0, n;

	// Clock at 100 MHz
	always #5 clock = ~clock;

	gms_sequencer #(.AXES(3), .SAMPLE_CYCLES(50), .SETTLE_CYCLES(10), .STARTUP_CYCLES(200)) dut_u (
		.CLOCK(clock), .RESETN(resetn), .EXTERNAL_RESET_LOW(ext_n), .TRIGGER_INPUT(trig),
		.RATE_SAMPLE(sample), .ERR_INTEGRITY(errs[6]), .ERR_OPCOND(errs[5]),
		.ERR_OVERLOAD(errs[4]), .ERR_CHANNEL(errs[3]), .ERR_AXIS(errs[2:0]),
		.CHANNEL_SYNC(ch_sync), .SAMPLE_STROBE(strobe),
		.TX_VALID(tx_valid), .TX_READY(tx_ready),
		.TX_KIND(tx_kind), .TX_STATUS(tx_status), .TX_RATE_BYTE_HIGH(hi),
		.TX_RATE_BYTE_MID(md), .TX_RATE_BYTE_LOW(lo), .TX_LATENCY(lat),
		.AVS_ADDRESS(addr), .AVS_READ(rd), .AVS_WRITE(wr), .AVS_WRITEDATA(wdata),
		.AVS_BYTEENABLE(ben), .AVS_READDATA(rdata), .AVS_WAITREQUEST(wait_req));

	gms_host_model #(.AXES(3)) host_u (.clock(clock), .resetn(resetn), .tx_valid(tx_valid),
		.tx_ready(tx_ready), .tx_kind(tx_kind), .tx_status(tx_status), .tx_rate({hi, md, lo}),
		.slow(slow), .seen(seen), .kind(kind), .status(status), .rate(rate));

	// Count and report one comparison
	task automatic chk(input string name, input logic [71:0] exp, input logic [71:0] got);
		checked++;
		if (got !== exp)
		begin
			err_count++;
			$display("MISMATCH %s expected %h seen %h", name, exp, got);
		end
	endtask : chk

	// One bus access, held until waitrequest is seen low at a rising edge; the watchdog ends a hang
	task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d,
		input logic [3:0] b = 4'hf);
		n = 0;
		@(posedge clock);
		rd    <= !w;
		wr    <= w;
		addr  <= a;
		wdata <= d;
		ben   <= b;
		do
		begin
			@(posedge clock);
			n++;
		end
		while (wait_req !== 1'b0);
		q = rdata;
		rd <= 1'b0;
		wr <= 1'b0;
		chk("bus wait states", 1, n - 1);
	endtask : bus

	// Wait for the next accepted datagram; n gives the cycles waited
	task automatic next_dg(input int limit);
		logic [15:0] s;
		s = seen;
		n = 0;
		while (seen === s && n < limit)
		begin
			@(negedge clock);
			n++;
		end
		if (n >= limit) chk("datagram arrival", 0, 1);
	endtask : next_dg

	// Power-up: special datagrams in order, then flagged measurements, stalling host
	task automatic t_init();
		for (int k = 0; k < 3; k++)
		begin
			next_dg(2000);
			chk("special kind", k, kind);
		end
		next_dg(2000);
		chk("first measurement", gms_pkg::KIND_MEASURE, kind);
		chk("start-up status", 8'h55, status);
		chk("rate bytes", 72'h7f019a_fff25c_00e331, rate);
	endtask : t_init

	// Decimated output carries the newest sample every fourth tick
	task automatic t_decim();
		slow <= 1'b0;
		next_dg(400);
		@(posedge clock);
		sample <= 72'h000001_000002_800000;
		errs   <= 7'h6a;
		next_dg(400);
		chk("decimation spacing", 200, n);
		chk("newest sample", 72'h000080_000000_010200, rate);
		chk("errors still sent", 8'haa, status);
	endtask : t_decim

	// Triggered output: silent until a falling edge, one datagram per edge
	task automatic t_trig();
		logic [15:0] s;
		bus(0, `GMS_REG_CONFIG, 0);
		chk("config reset", 32'h400, q);
		bus(1, `GMS_REG_CONFIG, 32'h301, 4'h2);
		bus(0, `GMS_REG_CONFIG, 0);
		chk("byte enables", 32'h300, q);
		bus(1, `GMS_REG_CONFIG, 32'h401);
		bus(0, 4'h2, 0);
		chk("unmapped read", 0, q);
		repeat (300) @(posedge clock);
		s = seen;
		repeat (600) @(posedge clock);
		chk("no trigger no data", s, seen);
		trig <= 1'b0;
		next_dg(50);
		chk("trigger kind", gms_pkg::KIND_MEASURE, kind);
		chk("datagram latency", 0, lat);
		bus(0, `GMS_REG_LATENCY, 0);
		chk("latency register", 0, q);
		repeat (300) @(posedge clock);
		trig <= 1'b1;
		repeat (300) @(posedge clock);
		chk("one per edge", s + 16'h1, seen);
		for (int k = 1; k < 4; k++)
		begin
			bus(1, `GMS_REG_CTRL, 32'h1 << k);
			next_dg(50);
			chk("requested kind", k - 1, kind);
		end
	endtask : t_trig

	// Reset pin, then service round trip and reset command
	task automatic t_ext();
		@(posedge clock);
		ext_n <= 1'b0;
		repeat (20) @(posedge clock);
		bus(0, `GMS_REG_STATUS, 0);
		chk("mode in reset", 0, q[10:8]);
		chk("channels held", 1, ch_sync);
		chk("no sample strobe in settle", 0, strobe);
		repeat (30) @(posedge clock);
		bus(0, `GMS_REG_STATUS, 0);
		chk("still in reset", 0, q[10:8]);
		ext_n <= 1'b1;
		for (int k = 0; k < 3; k++)
		begin
			next_dg(2000);
			chk("special after pin", k, kind);
		end
		repeat (10) @(posedge clock);
		bus(0, `GMS_REG_STATUS, 0);
		chk("start-up flag", 1, q[6]);
		bus(1, `GMS_REG_CTRL, 32'h10);
		bus(1, `GMS_REG_CTRL, 32'h20);
		bus(0, `GMS_REG_STATUS, 0);
		chk("service to normal", 32'h500, q & 32'h740);
		bus(1, `GMS_REG_CTRL, 32'h1);
		next_dg(2000);
		chk("reset command", gms_pkg::KIND_PART, kind);
	endtask : t_ext

	// Print the counts and the verdict, then stop
	task automatic complete_run();
		$display("Checks %0d, mismatches %0d", checked, err_count);
		if (err_count == 0 && checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : complete_run

	// Main sequence; no host setup before the first datagrams
	initial
	begin
		repeat (10) @(posedge clock);
		resetn <= 1'b1;
		t_init();
		t_decim();
		t_trig();
		t_ext();
		complete_run();
	end

	// Watchdog, well beyond the roughly 2400 cycles the tests need
	initial
	begin
		repeat (30000) @(posedge clock);
		err_count++;
		complete_run();
	end
endmodule : tb
